/* hw/hlie_consts.svh */
// Operation
// - Failed transceiver register access sets its flag before the next access.
// - Link reinitialisation from the transceiver sets the reinit event flag.
// - Node ID stream end sets done flag; reinit clears it same cycle.
// - Sticky stream-done flag sets with primary, survives reinit.
// - Event bits 14 to 10 read zero and ignore writes.
// - Atomic reply not acknowledged complete sets the atomic reply error flag.
// - Host bus error on stored acknowledged write sets buffered write error.
// - Timed receive summary is unlatched OR of context events ANDed with masks.
// - Timed transmit summary is unlatched OR of context events ANDed with masks.
// - Reply packet stored and descriptor updated sets reply packet arrived.
// - Request packet stored and descriptor updated sets request packet arrived.
// - Reply receive descriptor completion conditionally sets its DMA done flag.
// - Request receive descriptor completion conditionally sets its DMA done flag.
// - Reply send context command completion conditionally sets reply send done.
// - Request send context command completion conditionally sets request send done.
// - Reading mask set or mask clear address returns the mask contents.
// - Mask bits enable same-position events; bit 31 gates, bit 30 extra source.
// - Interrupt output only while global gate is one, regardless of masks.
// - Extra event source requests only when its event and mask are one.
// - Software, late-ack, transceiver byte events request only with mask set.
// - Mask bit 28 reads zero and ignores writes.
// - Timed context clear address reads events ANDed with their masks.
`ifndef HLIE_CONSTS_SVH
`define HLIE_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HLIE_OFS_EVT_SET    8'h80
`define HLIE_OFS_EVT_CLR    8'h84
`define HLIE_OFS_MSK_SET    8'h88
`define HLIE_OFS_MSK_CLR    8'h8C
`define HLIE_OFS_TTX_CLR    8'h94
`define HLIE_OFS_TRX_CLR    8'hA4

// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define HLIE_B_GATE         31
`define HLIE_B_EXTRA        30
`define HLIE_B_SOFT         29
`define HLIE_B_ACK_LATE     27
`define HLIE_B_XCVR_BYTE    26
`define HLIE_B_CYC_HI       25
`define HLIE_B_CYC_LO       19
`define HLIE_B_ACC_FAIL     18
`define HLIE_B_REINIT       17
`define HLIE_B_ID_DONE      16
`define HLIE_B_ID_STICKY    15
`define HLIE_B_ATOMIC_ERR   9
`define HLIE_B_BUF_WR_ERR   8
`define HLIE_B_TRX_SUM      7
`define HLIE_B_TTX_SUM      6
`define HLIE_B_REPLY_PKT    5
`define HLIE_B_REQ_PKT      4
`define HLIE_B_REPLY_RXDMA  3
`define HLIE_B_REQ_RXDMA    2
`define HLIE_B_REPLY_SEND   1
`define HLIE_B_REQ_SEND     0

// ----------------------------------------------------------------
// Field masks and reset values
// ----------------------------------------------------------------
`define HLIE_EVT_WR_MASK    32'h6FFF_833F
`define HLIE_MSK_WR_MASK    32'hEFFF_83FF
`define HLIE_IRQ_SRC_MASK   32'h7FFF_FFFF
`define HLIE_EVT_RESET      32'h0000_0000
`define HLIE_MSK_RESET      32'h0000_0000
`define HLIE_ZERO32         32'h0000_0000

`endif

/* hw/hlie_pkg.sv */
package hlie_pkg;

  // Whole state of the event and mask block
  typedef struct packed {
    logic [31:0] event_ff;
    logic [31:0] mask_ff;
    logic [31:0] rdata_ff;
    logic        irq_ff;
  } hlie_state_t;

endpackage

/* hw/hlie_sync3.sv */
`timescale 1ns/10ps
`include "hlie_consts.svh"

module hlie_sync3 #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         reset_n_i,
  // Pin side
  input  wire logic [W-1:0] pin_i,
  // Filtered level
  output logic      [W-1:0] level_o
);

  // ----------------------------------------------------------------
  // Three-stage capture, accept only when stages two and three agree
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] lvl_ff;
  } hlie_sync_t;

  hlie_sync_t st_ff;
  hlie_sync_t nxt_st;

  // Stage one feeds stage two only; the filter looks at two and three
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.s1_ff = pin_i;
    nxt_st.s2_ff = st_ff.s1_ff;
    nxt_st.s3_ff = st_ff.s2_ff;
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2_ff[i] == st_ff.s3_ff[i]) begin
        nxt_st.lvl_ff[i] = st_ff.s3_ff[i];
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_o = st_ff.lvl_ff;

endmodule

/* hw/hlie_ctx_summary.sv */
`timescale 1ns/10ps
`include "hlie_consts.svh"

module hlie_ctx_summary #(
  parameter int N = 8
) (
  // Per-context event and mask
  input  wire logic [N-1:0] event_i,
  input  wire logic [N-1:0] mask_i,
  // Qualified view and summary
  output logic      [N-1:0] qualified_o,
  output logic              any_o
);

  // ----------------------------------------------------------------
  // Unlatched summary, follows the context bits with no delay
  // ----------------------------------------------------------------
  assign qualified_o = event_i & mask_i;
  assign any_o       = |qualified_o;

endmodule

/* hw/hlie_event_mask.sv */
`timescale 1ns/10ps
`include "hlie_consts.svh"

module hlie_event_mask
  import hlie_pkg::*;
#(
  parameter int NTX = 8,
  parameter int NRX = 8,
  parameter int NGP = 2
) (
  // Clock and reset
  input  wire logic           mclk_i,
  input  wire logic           reset_n_i,
  // Register port
  input  wire logic [7:0]     addr_i,
  input  wire logic [31:0]    wdata_i,
  input  wire logic           wr_i,
  input  wire logic           rd_i,
  output logic      [31:0]    rdata_o,
  // Event pulses from link logic
  input  wire logic           register_access_failed_flag_i,
  input  wire logic           link_reinit_event_i,
  input  wire logic           node_id_stream_done_i,
  input  wire logic           atomic_reply_error_i,
  input  wire logic           buffered_write_error_i,
  input  wire logic           reply_packet_arrived_i,
  input  wire logic           request_packet_arrived_i,
  input  wire logic           async_reply_receive_dma_done_i,
  input  wire logic           async_request_receive_dma_done_i,
  input  wire logic           reply_send_done_i,
  input  wire logic           request_send_done_i,
  input  wire logic           ack_late_event_i,
  input  wire logic           transceiver_reg_byte_arrived_i,
  input  wire logic [6:0]     cycle_events_i,
  // Extra source pins, asynchronous
  input  wire logic [NGP-1:0] extra_event_pins_i,
  // Timed context bits from the context registers
  input  wire logic [NTX-1:0] ttx_ctx_event_i,
  input  wire logic [NTX-1:0] ttx_ctx_mask_i,
  input  wire logic [NRX-1:0] trx_ctx_event_i,
  input  wire logic [NRX-1:0] trx_ctx_mask_i,
  // Interrupt
  output logic                irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Set and clear update, a set always beats a clear in the same cycle
  function automatic logic [31:0] set_clr(input logic [31:0] cur,
                                          input logic [31:0] set_v,
                                          input logic [31:0] clr_v,
                                          input logic [31:0] keep);
    set_clr = ((cur & ~clr_v) | set_v) & keep;
  endfunction

  // Zero extension of a context vector into a register word
  function automatic logic [31:0] widen(input logic [31:0] v, input int n);
    logic [31:0] m;
    m     = `HLIE_ZERO32;
    for (int i = 0; i < 32; i++) begin
      m[i] = (i < n);
    end
    widen = v & m;
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  logic [NGP-1:0] gp_level;
  logic [NTX-1:0] ttx_qual;
  logic [NRX-1:0] trx_qual;
  logic           ttx_any;
  logic           trx_any;

  // Pins cross into the core clock through three stages
  hlie_sync3 #(
    .W         (NGP)
  ) u_gp_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (extra_event_pins_i),
    .level_o   (gp_level)
  );

  // Transmit context summary
  hlie_ctx_summary #(
    .N           (NTX)
  ) u_ttx_sum (
    .event_i     (ttx_ctx_event_i),
    .mask_i      (ttx_ctx_mask_i),
    .qualified_o (ttx_qual),
    .any_o       (ttx_any)
  );

  // Receive context summary
  hlie_ctx_summary #(
    .N           (NRX)
  ) u_trx_sum (
    .event_i     (trx_ctx_event_i),
    .mask_i      (trx_ctx_mask_i),
    .qualified_o (trx_qual),
    .any_o       (trx_any)
  );

  // ----------------------------------------------------------------
  // Hardware event vector
  // ----------------------------------------------------------------
  logic [31:0] hw_set;

  // One bit per event source, two for stream done (16 and 15); reserved positions stay zero
  always_comb begin
    hw_set                         = `HLIE_ZERO32;
    hw_set[`HLIE_B_EXTRA]          = |gp_level;
    hw_set[`HLIE_B_ACK_LATE]       = ack_late_event_i;
    hw_set[`HLIE_B_XCVR_BYTE]      = transceiver_reg_byte_arrived_i;
    hw_set[`HLIE_B_CYC_HI:`HLIE_B_CYC_LO] = cycle_events_i;
    hw_set[`HLIE_B_ACC_FAIL]       = register_access_failed_flag_i;
    hw_set[`HLIE_B_REINIT]         = link_reinit_event_i;
    hw_set[`HLIE_B_ID_DONE]        = node_id_stream_done_i;
    hw_set[`HLIE_B_ID_STICKY]      = node_id_stream_done_i;
    hw_set[`HLIE_B_ATOMIC_ERR]     = atomic_reply_error_i;
    hw_set[`HLIE_B_BUF_WR_ERR]     = buffered_write_error_i;
    hw_set[`HLIE_B_REPLY_PKT]      = reply_packet_arrived_i;
    hw_set[`HLIE_B_REQ_PKT]        = request_packet_arrived_i;
    hw_set[`HLIE_B_REPLY_RXDMA]    = async_reply_receive_dma_done_i;
    hw_set[`HLIE_B_REQ_RXDMA]      = async_request_receive_dma_done_i;
    hw_set[`HLIE_B_REPLY_SEND]     = reply_send_done_i;
    hw_set[`HLIE_B_REQ_SEND]       = request_send_done_i;
  end

  // ----------------------------------------------------------------
  // State and next state
  // ----------------------------------------------------------------
  hlie_state_t st_ff;
  hlie_state_t nxt_st;
  logic [31:0] evt_view;
  logic [31:0] sw_evt_set;
  logic [31:0] sw_evt_clr;
  logic [31:0] sw_msk_set;
  logic [31:0] sw_msk_clr;

  // Write strobes turned into per-bit set and clear words
  assign sw_evt_set = (wr_i && addr_i == `HLIE_OFS_EVT_SET) ? wdata_i : `HLIE_ZERO32;
  assign sw_evt_clr = (wr_i && addr_i == `HLIE_OFS_EVT_CLR) ? wdata_i : `HLIE_ZERO32;
  assign sw_msk_set = (wr_i && addr_i == `HLIE_OFS_MSK_SET) ? wdata_i : `HLIE_ZERO32;
  assign sw_msk_clr = (wr_i && addr_i == `HLIE_OFS_MSK_CLR) ? wdata_i : `HLIE_ZERO32;

  // Summary bits are not stored, they are merged into the event read view and the interrupt
  always_comb begin
    evt_view                 = st_ff.event_ff;
    evt_view[`HLIE_B_TRX_SUM] = trx_any;
    evt_view[`HLIE_B_TTX_SUM] = ttx_any;
  end

  // Next state
  always_comb begin
    nxt_st          = st_ff;
    // Latched events; writable mask keeps reserved and summary bits at zero
    nxt_st.event_ff = set_clr(st_ff.event_ff, sw_evt_set | hw_set, sw_evt_clr,
                              `HLIE_EVT_WR_MASK);
    // Reinit wipes the primary done flag, even against a same-cycle set
    if (link_reinit_event_i) begin
      nxt_st.event_ff[`HLIE_B_ID_DONE] = 1'b0;
    end
    // Mask update, bit 28 and 14 to 10 never stick
    nxt_st.mask_ff  = set_clr(st_ff.mask_ff, sw_msk_set, sw_msk_clr,
                              `HLIE_MSK_WR_MASK);
    // Read data stand for the one cycle after the strobe only
    nxt_st.rdata_ff = `HLIE_ZERO32;
    if (rd_i) begin
      case (addr_i)
        `HLIE_OFS_EVT_SET, `HLIE_OFS_EVT_CLR: begin
          nxt_st.rdata_ff = evt_view;
        end
        `HLIE_OFS_MSK_SET, `HLIE_OFS_MSK_CLR: begin
          nxt_st.rdata_ff = st_ff.mask_ff;
        end
        `HLIE_OFS_TTX_CLR: begin
          nxt_st.rdata_ff = widen(32'(ttx_qual), NTX);
        end
        `HLIE_OFS_TRX_CLR: begin
          nxt_st.rdata_ff = widen(32'(trx_qual), NRX);
        end
        default: begin
          nxt_st.rdata_ff = `HLIE_ZERO32;
        end
      endcase
    end
    // Gate and per-bit enables; one register stage keeps the pin glitch free
    nxt_st.irq_ff = st_ff.mask_ff[`HLIE_B_GATE] &
                    (|(evt_view & st_ff.mask_ff & `HLIE_IRQ_SRC_MASK));
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_ff.event_ff <= `HLIE_EVT_RESET;
      st_ff.mask_ff  <= `HLIE_MSK_RESET;
      st_ff.rdata_ff <= `HLIE_ZERO32;
      st_ff.irq_ff   <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = st_ff.rdata_ff;
  assign irq_o   = st_ff.irq_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // Read of the event word at either address
  sequence evt_read_s;
    rd_i && (addr_i == `HLIE_OFS_EVT_SET || addr_i == `HLIE_OFS_EVT_CLR);
  endsequence

  // Reinit pulse with the sticky flag already up and no clear aimed at it
  sequence sticky_hold_s;
    link_reinit_event_i && st_ff.event_ff[`HLIE_B_ID_STICKY] &&
    !sw_evt_clr[`HLIE_B_ID_STICKY];
  endsequence

  // Stable enabled software event with the gate open for two cycles
  sequence soft_armed_s;
    (st_ff.mask_ff[`HLIE_B_GATE] && st_ff.mask_ff[`HLIE_B_SOFT] &&
     st_ff.event_ff[`HLIE_B_SOFT]) [*2];
  endsequence

  acc_fail_flag_a: assert property (
    register_access_failed_flag_i |=> st_ff.event_ff[`HLIE_B_ACC_FAIL])
    else $error("access failure flag not set");

  reinit_wipe_a: assert property (
    link_reinit_event_i |=> st_ff.event_ff[`HLIE_B_REINIT] &&
                            !st_ff.event_ff[`HLIE_B_ID_DONE])
    else $error("reinit did not set flag or clear done");

  stream_done_a: assert property (
    node_id_stream_done_i && !link_reinit_event_i |=> st_ff.event_ff[`HLIE_B_ID_DONE])
    else $error("stream done flag not set");

  sticky_keep_a: assert property (
    sticky_hold_s |=> st_ff.event_ff[`HLIE_B_ID_STICKY] ##1
                      (st_ff.event_ff[`HLIE_B_ID_STICKY] ||
                       $past(sw_evt_clr[`HLIE_B_ID_STICKY])))
    else $error("sticky done flag lost on reinit");

  resvd_zero_a: assert property (
    evt_read_s |=> rdata_o[14:10] == 5'h0 && rdata_o[28] == 1'b0)
    else $error("reserved event bits read nonzero");

  rx_summary_a: assert property (
    evt_read_s |=> rdata_o[`HLIE_B_TRX_SUM] == $past(|(trx_ctx_event_i & trx_ctx_mask_i)))
    else $error("receive summary wrong");

  tx_summary_a: assert property (
    evt_read_s |=> rdata_o[`HLIE_B_TTX_SUM] == $past(|(ttx_ctx_event_i & ttx_ctx_mask_i)))
    else $error("transmit summary wrong");

  mask_read_a: assert property (
    rd_i && (addr_i == `HLIE_OFS_MSK_SET || addr_i == `HLIE_OFS_MSK_CLR)
    |=> rdata_o == $past(st_ff.mask_ff))
    else $error("mask read mismatch");

  gate_closed_a: assert property (
    !st_ff.mask_ff[`HLIE_B_GATE] |=> !irq_o)
    else $error("interrupt with gate closed");

  soft_irq_a: assert property (
    soft_armed_s |-> irq_o)
    else $error("enabled soft event gave no interrupt");

  mask28_zero_a: assert property (
    sw_msk_set[28] |=> !st_ff.mask_ff[28])
    else $error("mask bit 28 stuck");

  ctx_clear_read_a: assert property (
    rd_i && addr_i == `HLIE_OFS_TTX_CLR
    |=> rdata_o[NTX-1:0] == $past(ttx_ctx_event_i & ttx_ctx_mask_i))
    else $error("context clear read wrong");

  set_clear_a: assert property (
    sw_evt_clr[`HLIE_B_REQ_SEND] && !request_send_done_i && !sw_evt_set[`HLIE_B_REQ_SEND]
    |=> !st_ff.event_ff[`HLIE_B_REQ_SEND])
    else $error("clear write did not clear");

  sticky_set_a: assert property (
    node_id_stream_done_i |=> st_ff.event_ff[`HLIE_B_ID_STICKY])
    else $error("sticky done flag not set");

  atomic_err_a: assert property (
    atomic_reply_error_i |=> st_ff.event_ff[`HLIE_B_ATOMIC_ERR])
    else $error("atomic reply error flag not set");

  buf_wr_err_a: assert property (
    buffered_write_error_i |=> st_ff.event_ff[`HLIE_B_BUF_WR_ERR])
    else $error("buffered write error flag not set");

  reply_pkt_a: assert property (
    reply_packet_arrived_i |=> st_ff.event_ff[`HLIE_B_REPLY_PKT])
    else $error("reply packet flag not set");

  req_pkt_a: assert property (
    request_packet_arrived_i |=> st_ff.event_ff[`HLIE_B_REQ_PKT])
    else $error("request packet flag not set");

  reply_rxdma_a: assert property (
    async_reply_receive_dma_done_i |=> st_ff.event_ff[`HLIE_B_REPLY_RXDMA])
    else $error("reply receive dma flag not set");

  req_rxdma_a: assert property (
    async_request_receive_dma_done_i |=> st_ff.event_ff[`HLIE_B_REQ_RXDMA])
    else $error("request receive dma flag not set");

  reply_send_a: assert property (
    reply_send_done_i |=> st_ff.event_ff[`HLIE_B_REPLY_SEND])
    else $error("reply send flag not set");

  req_send_a: assert property (
    request_send_done_i |=> st_ff.event_ff[`HLIE_B_REQ_SEND])
    else $error("request send flag not set");

  extra_src_a: assert property (
    (|gp_level) |=> st_ff.event_ff[`HLIE_B_EXTRA])
    else $error("extra source flag not set");

  masked_irq_a: assert property (
    st_ff.mask_ff[`HLIE_B_GATE] && st_ff.mask_ff[`HLIE_B_REPLY_SEND] &&
    st_ff.event_ff[`HLIE_B_REPLY_SEND] |=> irq_o)
    else $error("enabled event gave no interrupt");

  rx_ctx_read_a: assert property (
    rd_i && addr_i == `HLIE_OFS_TRX_CLR
    |=> rdata_o[NRX-1:0] == $past(trx_ctx_event_i & trx_ctx_mask_i))
    else $error("receive context clear read wrong");

  // Read data must fall back to zero when no read is under way
  rdata_idle_a: assert property (
    !rd_i |=> rdata_o == `HLIE_ZERO32)
    else $error("read data stood too long");

endmodule

/* tb/test_hlie_event_mask.sv */
`timescale 1ns/10ps
`include "hlie_consts.svh"

module test_hlie_event_mask;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk_i;
  logic        reset_n_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic [12:0] ev_v;
  logic [6:0]  cyc_v;
  logic [1:0]  pins_v;
  logic [7:0]  ttx_ev;
  logic [7:0]  ttx_mk;
  logic [7:0]  trx_ev;
  logic [7:0]  trx_mk;
  logic        irq_o;
  logic [31:0] rd_val;
  int          err_count;
  int          n_checks;
  // Expected word per event input, same order as ev_v
  logic [31:0] ev_exp [13] = '{32'h0004_0000, 32'h0002_0000, 32'h0001_8000, 32'h0000_0200,
    32'h0000_0100, 32'h0000_0020, 32'h0000_0010, 32'h0000_0008, 32'h0000_0004,
    32'h0000_0002, 32'h0000_0001, 32'h0800_0000, 32'h0400_0000};

  // ----------------------------------------------------------------
  // Design under test
  // ----------------------------------------------------------------
  hlie_event_mask #(.NTX(8), .NRX(8), .NGP(2)) i_dut (
    .mclk_i                           (mclk_i),
    .reset_n_i                        (reset_n_i),
    .addr_i                           (addr_i),
    .wdata_i                          (wdata_i),
    .wr_i                             (wr_i),
    .rd_i                             (rd_i),
    .rdata_o                          (rdata_o),
    .register_access_failed_flag_i    (ev_v[0]),
    .link_reinit_event_i              (ev_v[1]),
    .node_id_stream_done_i            (ev_v[2]),
    .atomic_reply_error_i             (ev_v[3]),
    .buffered_write_error_i           (ev_v[4]),
    .reply_packet_arrived_i           (ev_v[5]),
    .request_packet_arrived_i         (ev_v[6]),
    .async_reply_receive_dma_done_i   (ev_v[7]),
    .async_request_receive_dma_done_i (ev_v[8]),
    .reply_send_done_i                (ev_v[9]),
    .request_send_done_i              (ev_v[10]),
    .ack_late_event_i                 (ev_v[11]),
    .transceiver_reg_byte_arrived_i   (ev_v[12]),
    .cycle_events_i                   (cyc_v),
    .extra_event_pins_i               (pins_v),
    .ttx_ctx_event_i                  (ttx_ev),
    .ttx_ctx_mask_i                   (ttx_mk),
    .trx_ctx_event_i                  (trx_ev),
    .trx_ctx_mask_i                   (trx_mk),
    .irq_o                            (irq_o)
  );

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // Whole run is well under 1500 cycles; 5000 leaves margin
  initial begin
    #(100 * 5000);
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  // Data stand only in the cycle after the read edge
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd_reg(a, rd_val);
    chk(rd_val, exp, what);
  endtask

  // hold=1: irq must stay at e for n cycles; hold=0: must reach e within n
  task automatic irq_chk(input logic e, input int n, input bit hold);
    bit ok;
    ok = hold;
    repeat (n) begin
      @(posedge mclk_i);
      #1;
      if (hold && irq_o !== e) ok = 0;
      if (!hold && irq_o === e) ok = 1;
    end
    chk({31'h0, ok}, 32'h0000_0001, "irq level");
  endtask

  task automatic clear_all();
    wr_reg(`HLIE_OFS_EVT_CLR, 32'hFFFF_FFFF);
    wr_reg(`HLIE_OFS_MSK_CLR, 32'hFFFF_FFFF);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    rd_chk(`HLIE_OFS_EVT_SET, `HLIE_EVT_RESET, "event after reset");
    rd_chk(`HLIE_OFS_MSK_SET, `HLIE_MSK_RESET, "mask after reset");
    chk({31'h0, irq_o}, 32'h0, "irq after reset");
    $display("test reset_vals done");
  endtask

  task automatic t_events();
    for (int i = 0; i < 13; i++) begin
      @(posedge mclk_i);
      ev_v <= 13'h1 << i;
      @(posedge mclk_i);
      ev_v <= '0;
      rd_chk(`HLIE_OFS_EVT_SET, ev_exp[i], "single event");
      wr_reg(`HLIE_OFS_EVT_CLR, 32'hFFFF_FFFF);
      rd_chk(`HLIE_OFS_EVT_CLR, 32'h0, "event cleared");
    end
    for (int k = 0; k < 7; k++) begin
      @(posedge mclk_i);
      cyc_v <= 7'h1 << k;
      @(posedge mclk_i);
      cyc_v <= '0;
      rd_chk(`HLIE_OFS_EVT_SET, 32'h0008_0000 << k, "cycle event");
      wr_reg(`HLIE_OFS_EVT_CLR, 32'hFFFF_FFFF);
    end
    $display("test events done");
  endtask

  task automatic t_reinit();
    @(posedge mclk_i);
    ev_v <= 13'h004;
    @(posedge mclk_i);
    ev_v <= 13'h002;
    @(posedge mclk_i);
    ev_v <= '0;
    rd_chk(`HLIE_OFS_EVT_SET, 32'h0002_8000, "reinit after done");
    wr_reg(`HLIE_OFS_EVT_CLR, 32'hFFFF_FFFF);
    // Both in one cycle: reinit wins over the primary done flag
    @(posedge mclk_i);
    ev_v <= 13'h006;
    @(posedge mclk_i);
    ev_v <= '0;
    rd_chk(`HLIE_OFS_EVT_SET, 32'h0002_8000, "reinit with done");
    wr_reg(`HLIE_OFS_EVT_CLR, 32'hFFFF_FFFF);
    $display("test reinit done");
  endtask

  task automatic t_regs();
    wr_reg(`HLIE_OFS_EVT_SET, 32'hFFFF_FFFF);
    rd_chk(`HLIE_OFS_EVT_SET, `HLIE_EVT_WR_MASK, "event reserved");
    wr_reg(`HLIE_OFS_EVT_CLR, 32'hFFFF_FFFF);
    wr_reg(`HLIE_OFS_MSK_SET, 32'hFFFF_FFFF);
    rd_chk(`HLIE_OFS_MSK_SET, `HLIE_MSK_WR_MASK, "mask reserved");
    rd_chk(`HLIE_OFS_MSK_CLR, `HLIE_MSK_WR_MASK, "mask via clear");
    wr_reg(`HLIE_OFS_MSK_CLR, 32'hFFFF_FFFF);
    wr_reg(`HLIE_OFS_MSK_SET, 32'h0000_0001);
    wr_reg(`HLIE_OFS_MSK_SET, 32'h0000_0002);
    rd_chk(`HLIE_OFS_MSK_SET, 32'h0000_0003, "mask set keeps");
    wr_reg(`HLIE_OFS_MSK_CLR, 32'h0000_0001);
    rd_chk(`HLIE_OFS_MSK_CLR, 32'h0000_0002, "mask clear keeps");
    // Unmapped place reads zero and swallows writes
    wr_reg(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0, "unmapped read");
    rd_chk(`HLIE_OFS_EVT_SET, 32'h0, "unmapped write");
    clear_all();
    $display("test regs done");
  endtask

  task automatic t_summary();
    @(posedge mclk_i);
    ttx_ev <= 8'h81;
    ttx_mk <= 8'h01;
    rd_chk(`HLIE_OFS_EVT_SET, 32'h0000_0040, "tx summary");
    rd_chk(`HLIE_OFS_TTX_CLR, 32'h0000_0001, "tx ctx view");
    @(posedge mclk_i);
    trx_ev <= 8'h10;
    trx_mk <= 8'h30;
    rd_chk(`HLIE_OFS_EVT_SET, 32'h0000_00C0, "both summaries");
    rd_chk(`HLIE_OFS_TRX_CLR, 32'h0000_0010, "rx ctx view");
    @(posedge mclk_i);
    ttx_mk <= 8'h00;
    rd_chk(`HLIE_OFS_EVT_SET, 32'h0000_0080, "summary unlatched");
    @(posedge mclk_i);
    trx_ev <= 8'h00;
    rd_chk(`HLIE_OFS_EVT_SET, 32'h0, "rx summary gone");
    $display("test summary done");
  endtask

  task automatic t_irq();
    wr_reg(`HLIE_OFS_MSK_SET, 32'h0000_0002);
    @(posedge mclk_i);
    ev_v <= 13'h200;
    @(posedge mclk_i);
    ev_v <= '0;
    irq_chk(1'b0, 5, 1);
    wr_reg(`HLIE_OFS_MSK_SET, 32'h8000_0000);
    irq_chk(1'b1, 4, 0);
    wr_reg(`HLIE_OFS_EVT_CLR, 32'h0000_0002);
    irq_chk(1'b0, 4, 0);
    // Software event without its mask bit stays quiet
    wr_reg(`HLIE_OFS_EVT_SET, 32'h2000_0000);
    irq_chk(1'b0, 5, 1);
    wr_reg(`HLIE_OFS_MSK_SET, 32'h2000_0000);
    irq_chk(1'b1, 4, 0);
    wr_reg(`HLIE_OFS_MSK_CLR, 32'h8000_0000);
    irq_chk(1'b0, 4, 0);
    clear_all();
    $display("test irq done");
  endtask

  task automatic t_extra();
    wr_reg(`HLIE_OFS_MSK_SET, 32'h4000_0000);
    @(posedge mclk_i);
    pins_v <= 2'b10;
    repeat (8) @(posedge mclk_i);
    pins_v <= 2'b00;
    repeat (8) @(posedge mclk_i);
    rd_chk(`HLIE_OFS_EVT_SET, 32'h4000_0000, "extra source");
    irq_chk(1'b0, 3, 1);
    wr_reg(`HLIE_OFS_MSK_SET, 32'h8000_0000);
    irq_chk(1'b1, 4, 0);
    wr_reg(`HLIE_OFS_MSK_CLR, 32'h4000_0000);
    irq_chk(1'b0, 4, 0);
    clear_all();
    $display("test extra done");
  endtask

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    n_checks  = 0;
    reset_n_i = 1'b0;
    addr_i    = '0;
    wdata_i   = '0;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    ev_v      = '0;
    cyc_v     = '0;
    pins_v    = '0;
    ttx_ev    = '0;
    ttx_mk    = '0;
    trx_ev    = '0;
    trx_mk    = '0;
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset_vals();
    t_events();
    t_reinit();
    t_regs();
    t_summary();
    t_irq();
    t_extra();
    final_report();
  end
endmodule
